// [logic/emc_cfg_bank.sv]
/*
  Configuration and address filter register bank of one MAC channel,
  reached over the host interface (10-bit address, write and read
  strobes, read data one cycle after the strobe).
  Assumes frame-activity flags from the receive and transmit datapaths,
  all synchronous to ref_clk.
*/
// Notes on behaviour
// RL1: Writes accepted any time; rx/tx use new settings only between frames.
// RL2: Soft reset bits act immediately, bypassing the between-frames wait.
// RL3: Address filter registers take effect immediately.
// RL4: Host should write filter registers only while no frame is received.
// RL5: Twelve registers decoded on a 10-bit address at fixed offsets.
// RL6: 48-bit pause address split: low word, then rx control bits 15:0.
// RL7: First wire byte of the pause address sits in its lowest byte.
// RL8: Integrator should make pause default equal the unicast default.
// RL9: Rx control bit 25 set skips the length/type check.
// RL10: Rx control bit 26 selects half duplex when set.
// RL11: Rx control bit 27 accepts tagged frames, payload limit plus four.
// RL12: Rx control bit 28 enables receiver; clear ignores receive port.
// RL13: Rx control bit 29 forwards FCS to client; FCS always checked.
// RL14: Rx control bit 30 accepts frames beyond standard maximum length.
// RL15: Rx control bit 31 resets receiver and its registers, self-clears.
// RL16: Tx bit 25 samples client gap delay at each frame start.
// RL17: Tx bit 26 selects half duplex, only at 10 and 100 Mb/s.
// RL18: Tx bit 27 permits sending tagged frames.
// RL19: Tx bit 28 enables the transmitter.
// RL20: Tx bit 29 means client supplies FCS with the frame.
// RL21: Tx bit 30 permits sending frames beyond standard maximum.
// RL22: Tx bit 31 resets transmitter and its registers, self-clears.
// RL23: Reserved bits read zero and ignore writes.
`include "emc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module emc_cfg_bank
  import emc_pkg::*;
#(
  parameter int ADDR_W = `EMC_ADDR_W,
  parameter int GAP_W = `EMC_GAP_W,
  parameter int RST_HOLD = `EMC_RST_HOLD,
  parameter logic [47:0] pause_station_address_default = 48'h000000000000,
  parameter logic [47:0] unicast_station_address_default = 48'h000000000000,
  parameter logic length_type_check_off_default = 1'b0,
  parameter logic rx_half_duplex_default = 1'b0,
  parameter logic rx_tagged_frames_default = 1'b0,
  parameter logic rx_on_default = 1'b1,
  parameter logic rx_pass_checksum_default = 1'b0,
  parameter logic rx_oversize_default = 1'b0,
  parameter logic rx_soft_reset_default = 1'b0,
  parameter logic tx_gap_adjust_default = 1'b0,
  parameter logic tx_half_duplex_default = 1'b0,
  parameter logic tx_tagged_frames_default = 1'b0,
  parameter logic tx_on_default = 1'b1,
  parameter logic tx_client_checksum_default = 1'b0,
  parameter logic tx_oversize_default = 1'b0,
  parameter logic tx_soft_reset_default = 1'b0,
  parameter logic [31:0] flow_default = 32'h00000000,
  parameter logic [31:0] mode_default = 32'h00000000,
  parameter logic [31:0] mgmt_default = 32'h00000000,
  parameter logic [31:0] filter_mode_default = 32'h00000000
)
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic sys_rst, // Sync reset, high
  input wire logic [ADDR_W-1:0] host_addr, // Register address
  input wire logic host_wr, // Write strobe
  input wire logic host_rd, // Read strobe
  input wire logic [31:0] host_wdata, // Write data
  output logic [31:0] host_rdata, // Read data
  output logic host_rd_valid, // Read data valid pulse
  input wire logic rx_frame_active, // Receiver mid-frame
  input wire logic tx_frame_active, // Transmitter mid-frame
  input wire logic [GAP_W-1:0] client_gap_delay_value, // Client gap delay
  input wire logic [31:0] serial_link_status, // Link status word
  output logic rx_soft_reset, // Receiver reset
  output logic tx_soft_reset, // Transmitter reset
  output logic [47:0] rx_pause_address, // Pause station address
  output logic rx_lt_check_off, // Skip length/type check
  output logic rx_half_duplex, // Rx half duplex
  output logic rx_tagged_frames, // Rx accepts tagged
  output logic rx_on, // Receiver enable
  output logic rx_pass_checksum, // Forward FCS to client
  output logic rx_oversize, // Accept long frames
  output logic [15:0] rx_max_len, // Rx length limit
  output logic tx_gap_adjust, // Gap adjust enable
  output logic tx_half_duplex, // Tx half duplex, effective
  output logic tx_tagged_frames, // Tx permits tagged
  output logic tx_on, // Transmitter enable
  output logic tx_client_checksum, // Client supplies FCS
  output logic tx_oversize, // Send long frames
  output logic [GAP_W-1:0] tx_gap_delay, // Sampled gap delay
  output logic [31:0] flow_control_word, // Flow control word
  output logic [31:0] mac_mode_word, // Mode word
  output logic [31:0] management_word, // Management word
  output logic [47:0] station_address, // Unicast address
  output logic [31:0] extra_table_low, // Table access low
  output logic [31:0] extra_table_high, // Table access high
  output logic [31:0] filter_mode_word // Filter mode word
);
  localparam int NGEN = 8;
  localparam logic [5:0] RX_CTRL_INIT = {rx_oversize_default,
    rx_pass_checksum_default, rx_on_default, rx_tagged_frames_default,
    rx_half_duplex_default, length_type_check_off_default};
  localparam logic [5:0] TX_CTRL_INIT = {tx_oversize_default,
    tx_client_checksum_default, tx_on_default, tx_tagged_frames_default,
    tx_half_duplex_default, tx_gap_adjust_default};
  localparam logic [53:0] RX_INIT = {RX_CTRL_INIT,
    pause_station_address_default};

  generate
    if (ADDR_W != 10)
    begin : g_bad_addr
      $error("emc_cfg_bank: ADDR_W must be 10");
    end
    if (GAP_W < 1 || GAP_W > 32)
    begin : g_bad_gap
      $error("emc_cfg_bank: GAP_W out of range");
    end
    if (rx_soft_reset_default || tx_soft_reset_default)
    begin : g_bad_rst
      $error("emc_cfg_bank: soft reset defaults must be 0");
    end
  endgenerate

  emc_reg_sel_t sel;
  logic [47:0] pause_reg;
  logic [5:0] rx_ctrl_reg;
  logic [5:0] tx_ctrl_reg;
  logic [31:0] gen_reg [NGEN];
  logic [31:0] host_rdata_reg;
  logic host_rd_valid_reg;
  logic rx_rst_trig;
  logic tx_rst_trig;
  logic rx_rst;
  logic tx_rst;
  logic [53:0] rx_active;
  logic [5:0] tx_active;
  logic [15:0] rx_max_len_reg;
  logic tx_half_reg;
  logic tx_frame_d_reg;
  logic [GAP_W-1:0] tx_gap_delay_reg;
  logic [31:0] rd_word;

  function automatic logic [31:0] gen_mask(input int i);
    if (i == 0)
      return `EMC_FLOW_MASK;
    else if (i == 1)
      return `EMC_MODE_MASK;
    else
      return `EMC_FULL_MASK;
  endfunction

  function automatic logic [31:0] gen_init(input int i);
    logic [31:0] v;
    v = 32'h00000000;
    case (i)
      0: v = flow_default;
      1: v = mode_default;
      2: v = mgmt_default;
      3: v = unicast_station_address_default[31:0];
      4: v = {16'h0000, unicast_station_address_default[47:32]};
      7: v = filter_mode_default;
      default: v = 32'h00000000;
    endcase
    return v & gen_mask(i);
  endfunction

  always_comb
  begin
    if (host_addr == `EMC_OFS_PAUSE_LO)
      sel = EMC_SEL_PAUSE_LO; // [RL5]
    else if (host_addr == `EMC_OFS_RX_CTRL)
      sel = EMC_SEL_RX_CTRL;
    else if (host_addr == `EMC_OFS_TX_CTRL)
      sel = EMC_SEL_TX_CTRL;
    else if (host_addr == `EMC_OFS_FLOW)
      sel = EMC_SEL_FLOW;
    else if (host_addr == `EMC_OFS_MODE)
      sel = EMC_SEL_MODE;
    else if (host_addr == `EMC_OFS_LINK)
      sel = EMC_SEL_LINK;
    else if (host_addr == `EMC_OFS_MGMT)
      sel = EMC_SEL_MGMT;
    else if (host_addr == `EMC_OFS_UNI_LO)
      sel = EMC_SEL_UNI_LO;
    else if (host_addr == `EMC_OFS_UNI_HI)
      sel = EMC_SEL_UNI_HI;
    else if (host_addr == `EMC_OFS_TBL_LO)
      sel = EMC_SEL_TBL_LO;
    else if (host_addr == `EMC_OFS_TBL_HI)
      sel = EMC_SEL_TBL_HI;
    else if (host_addr == `EMC_OFS_FILT)
      sel = EMC_SEL_FILT;
    else
      sel = EMC_SEL_NONE;
  end

  // Reset bits are never stored, so they always read back as 0
  assign rx_rst_trig = host_wr && (sel == EMC_SEL_RX_CTRL) &&
    host_wdata[`EMC_BIT_RESET]; // [RL15]
  assign tx_rst_trig = host_wr && (sel == EMC_SEL_TX_CTRL) &&
    host_wdata[`EMC_BIT_RESET]; // [RL22]

  emc_soft_reset #(.HOLD(RST_HOLD)) u_rx_rst
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .trigger(rx_rst_trig),
    .pulse(rx_rst)
  );

  emc_soft_reset #(.HOLD(RST_HOLD)) u_tx_rst
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .trigger(tx_rst_trig),
    .pulse(tx_rst)
  );

  // Byte 0 of the low word is the first byte on the wire
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || rx_rst_trig)
      pause_reg <= pause_station_address_default; // [RL15]
    else if (host_wr && sel == EMC_SEL_PAUSE_LO)
      pause_reg[31:0] <= host_wdata; // [RL6] [RL7]
    else if (host_wr && sel == EMC_SEL_RX_CTRL)
      pause_reg[47:32] <= host_wdata[15:0]; // [RL6]
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || rx_rst_trig)
      rx_ctrl_reg <= RX_CTRL_INIT; // [RL15]
    else if (host_wr && sel == EMC_SEL_RX_CTRL)
      rx_ctrl_reg <= host_wdata[`EMC_BIT_JUMBO:`EMC_BIT_LT_OFF]; // [RL23]
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || tx_rst_trig)
      tx_ctrl_reg <= TX_CTRL_INIT; // [RL22]
    else if (host_wr && sel == EMC_SEL_TX_CTRL)
      tx_ctrl_reg <= host_wdata[`EMC_BIT_JUMBO:`EMC_BIT_LT_OFF]; // [RL23]
  end

  // Remaining words are immediate; filter writes mid-frame are the host's
  // problem to avoid
  genvar gi;
  generate
    for (gi = 0; gi < NGEN; gi++)
    begin : g_gen
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
          gen_reg[gi] <= gen_init(gi);
        else if (host_wr && sel[3] && sel[2:0] == 3'(gi))
          gen_reg[gi] <= host_wdata & gen_mask(gi); // [RL3] [RL4] [RL23]
      end
    end
  endgenerate

  // Soft reset forces the active copy past any frame in flight
  emc_gap_shadow #(.W(54), .INIT(RX_INIT)) u_rx_shadow
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_frame(rx_frame_active), // [RL1]
    .force_load(rx_rst), // [RL2]
    .staged({rx_ctrl_reg, pause_reg}),
    .active(rx_active)
  );

  emc_gap_shadow #(.W(6), .INIT(TX_CTRL_INIT)) u_tx_shadow
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_frame(tx_frame_active), // [RL1]
    .force_load(tx_rst), // [RL2]
    .staged(tx_ctrl_reg),
    .active(tx_active)
  );

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rx_max_len_reg <= `EMC_STD_MAX_LEN;
    else if (rx_active[50])
      rx_max_len_reg <= `EMC_STD_MAX_LEN + `EMC_VLAN_EXTRA; // [RL11]
    else
      rx_max_len_reg <= `EMC_STD_MAX_LEN;
  end

  // Half duplex is meaningless at gigabit, so it is masked there
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      tx_half_reg <= 1'b0;
    else
      tx_half_reg <= tx_active[1] &&
        (gen_reg[1][31:30] != `EMC_SPEED_1000); // [RL17]
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      tx_frame_d_reg <= 1'b0;
    else
      tx_frame_d_reg <= tx_frame_active;
  end

  // Delay is held for the whole frame; loaded as zero at frame start when adjust is off
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || tx_rst)
      tx_gap_delay_reg <= '0;
    else if (tx_frame_active && !tx_frame_d_reg)
      tx_gap_delay_reg <= tx_active[0] ? client_gap_delay_value : '0; // [RL16]
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    case (sel)
      EMC_SEL_PAUSE_LO: rd_word = pause_reg[31:0];
      EMC_SEL_RX_CTRL: rd_word = {1'b0, rx_ctrl_reg, 9'h000,
        pause_reg[47:32]}; // [RL23]
      EMC_SEL_TX_CTRL: rd_word = {1'b0, tx_ctrl_reg, 25'h0000000};
      EMC_SEL_LINK: rd_word = serial_link_status & `EMC_LINK_MASK;
      EMC_SEL_FLOW: rd_word = gen_reg[0];
      EMC_SEL_MODE: rd_word = gen_reg[1];
      EMC_SEL_MGMT: rd_word = gen_reg[2];
      EMC_SEL_UNI_LO: rd_word = gen_reg[3];
      EMC_SEL_UNI_HI: rd_word = gen_reg[4];
      EMC_SEL_TBL_LO: rd_word = gen_reg[5];
      EMC_SEL_TBL_HI: rd_word = gen_reg[6];
      EMC_SEL_FILT: rd_word = gen_reg[7];
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      host_rdata_reg <= 32'h00000000;
      host_rd_valid_reg <= 1'b0;
    end
    else
    begin
      host_rd_valid_reg <= host_rd;
      if (host_rd)
        host_rdata_reg <= rd_word;
    end
  end

  assign host_rdata = host_rdata_reg;
  assign host_rd_valid = host_rd_valid_reg;
  assign rx_soft_reset = rx_rst;
  assign tx_soft_reset = tx_rst;
  assign rx_pause_address = rx_active[47:0]; // [RL6]
  assign rx_lt_check_off = rx_active[48]; // [RL9]
  assign rx_half_duplex = rx_active[49]; // [RL10]
  assign rx_tagged_frames = rx_active[50]; // [RL11]
  assign rx_on = rx_active[51]; // [RL12]
  assign rx_pass_checksum = rx_active[52]; // [RL13]
  assign rx_oversize = rx_active[53]; // [RL14]
  assign rx_max_len = rx_max_len_reg;
  assign tx_gap_adjust = tx_active[0]; // [RL16]
  assign tx_half_duplex = tx_half_reg;
  assign tx_tagged_frames = tx_active[2]; // [RL18]
  assign tx_on = tx_active[3]; // [RL19]
  assign tx_client_checksum = tx_active[4]; // [RL20]
  assign tx_oversize = tx_active[5]; // [RL21]
  assign tx_gap_delay = tx_gap_delay_reg;
  assign flow_control_word = gen_reg[0];
  assign mac_mode_word = gen_reg[1];
  assign management_word = gen_reg[2];
  assign station_address = {gen_reg[4][15:0], gen_reg[3]};
  assign extra_table_low = gen_reg[5];
  assign extra_table_high = gen_reg[6];
  assign filter_mode_word = gen_reg[7];
endmodule
`default_nettype wire

// [logic/emc_consts.svh]
/*
  Offsets, field positions, masks and reset values for the MAC channel
  configuration register bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef EMC_CONSTS_SVH
`define EMC_CONSTS_SVH

`define EMC_ADDR_W 10
`define EMC_DATA_W 32

`define EMC_OFS_PAUSE_LO 10'h200
`define EMC_OFS_RX_CTRL 10'h240
`define EMC_OFS_TX_CTRL 10'h280
`define EMC_OFS_FLOW 10'h2C0
`define EMC_OFS_MODE 10'h300
`define EMC_OFS_LINK 10'h320
`define EMC_OFS_MGMT 10'h340
`define EMC_OFS_UNI_LO 10'h380
`define EMC_OFS_UNI_HI 10'h384
`define EMC_OFS_TBL_LO 10'h388
`define EMC_OFS_TBL_HI 10'h38C
`define EMC_OFS_FILT 10'h390

`define EMC_BIT_LT_OFF 25
`define EMC_BIT_HALF 26
`define EMC_BIT_VLAN 27
`define EMC_BIT_ON 28
`define EMC_BIT_FCS 29
`define EMC_BIT_JUMBO 30
`define EMC_BIT_RESET 31

`define EMC_RX_CTRL_MASK 32'h7E00FFFF
`define EMC_TX_CTRL_MASK 32'h7E000000
`define EMC_FLOW_MASK 32'h60000000
`define EMC_MODE_MASK 32'hFF000000
`define EMC_LINK_MASK 32'hC000000F
`define EMC_FULL_MASK 32'hFFFFFFFF

`define EMC_SPEED_1000 2'h2
`define EMC_STD_MAX_LEN 16'h05EE
`define EMC_VLAN_EXTRA 16'h0004
`define EMC_RST_HOLD 2
`define EMC_GAP_W 8

`endif

// [logic/emc_gap_shadow.sv]
/*
  Active copy of a staged configuration word, loaded only when no frame
  is in flight, or at once on a forced load.
  Assumes a single clock and a synchronous active-high system reset.
*/
`timescale 1ns/100ps
`default_nettype none
module emc_gap_shadow
#(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic in_frame, // Frame in flight
  input wire logic force_load, // Load regardless of frame
  input wire logic [W-1:0] staged, // Host-written value
  output logic [W-1:0] active // Value the datapath sees
);
  logic [W-1:0] active_reg;

  generate
    if (W < 1)
    begin : g_bad
      $error("emc_gap_shadow: W must be positive");
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      active_reg <= INIT;
    else if (force_load || !in_frame)
      active_reg <= staged;
  end

  assign active = active_reg;
endmodule
`default_nettype wire

// [logic/emc_pkg.sv]
/*
  Types shared by the MAC channel configuration bank.
  Assumes nothing of its surroundings.
*/
package emc_pkg;
  typedef logic [31:0] emc_word_t;
  typedef enum logic [3:0] {
    EMC_SEL_NONE = 4'b0000,
    EMC_SEL_PAUSE_LO = 4'b0001,
    EMC_SEL_RX_CTRL = 4'b0010,
    EMC_SEL_TX_CTRL = 4'b0011,
    EMC_SEL_LINK = 4'b0100,
    EMC_SEL_FLOW = 4'b1000,
    EMC_SEL_MODE = 4'b1001,
    EMC_SEL_MGMT = 4'b1010,
    EMC_SEL_UNI_LO = 4'b1011,
    EMC_SEL_UNI_HI = 4'b1100,
    EMC_SEL_TBL_LO = 4'b1101,
    EMC_SEL_TBL_HI = 4'b1110,
    EMC_SEL_FILT = 4'b1111
  } emc_reg_sel_t;
endpackage

// [logic/emc_soft_reset.sv]
/*
  Self-clearing soft reset pulse of a fixed number of cycles.
  Assumes a single clock and a synchronous active-high system reset.
*/
`timescale 1ns/100ps
`default_nettype none
module emc_soft_reset
#(
  parameter int HOLD = 2
)
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic trigger, // One-cycle request
  output logic pulse // Reset out, HOLD cycles
);
  logic [7:0] count_reg;

  generate
    if (HOLD < 1 || HOLD > 255)
    begin : g_bad
      $error("emc_soft_reset: HOLD out of range");
    end
  endgenerate

  // Retrigger restarts the count
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      count_reg <= 8'h00;
    else if (trigger)
      count_reg <= 8'(HOLD);
    else if (count_reg != 8'h00)
      count_reg <= count_reg - 8'h01;
  end

  assign pulse = (count_reg != 8'h00);
endmodule
`default_nettype wire

// [sim/emc_cfg_bank_chk.sv]
/* Port checker for the MAC channel configuration bank.
   Assumes a bind onto emc_cfg_bank, one clock, sync active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module emc_cfg_bank_chk
#(
  parameter int ADDR_W = 10
)
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic [ADDR_W-1:0] host_addr, // Address
  input wire logic host_wr, // Write strobe
  input wire logic host_rd, // Read strobe
  input wire logic [31:0] host_wdata, // Write data
  input wire logic [31:0] host_rdata, // Read data
  input wire logic host_rd_valid, // Read valid
  input wire logic rx_frame_active, // Rx mid-frame
  input wire logic tx_frame_active, // Tx mid-frame
  input wire logic rx_soft_reset, // Rx reset
  input wire logic tx_soft_reset, // Tx reset
  input wire logic rx_on, // Rx enable
  input wire logic rx_tagged_frames, // Rx tagged
  input wire logic [15:0] rx_max_len, // Rx limit
  input wire logic tx_on, // Tx enable
  input wire logic tx_oversize, // Tx long frames
  input wire logic tx_half_duplex, // Tx half duplex
  input wire logic [31:0] mac_mode_word, // Mode word
  input wire logic [31:0] filter_mode_word // Filter mode
);
  logic mapped;
  assign mapped = host_addr inside {10'h200, 10'h240, 10'h280, 10'h2C0,
    10'h300, 10'h320, 10'h340, 10'h380, 10'h384, 10'h388, 10'h38C, 10'h390};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  property p_unmapped;
    host_rd && !mapped |=> host_rd_valid && host_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  property p_rx_pulse;
    host_wr && host_addr == 10'h240 && host_wdata[31]
      |=> rx_soft_reset [*2] ##1 !rx_soft_reset;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx reset pulse");
  property p_tx_pulse;
    host_wr && host_addr == 10'h280 && host_wdata[31]
      |=> tx_soft_reset [*2] ##1 !tx_soft_reset;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx reset pulse");
  property p_rx_hold;
    rx_frame_active && !host_wr && !rx_soft_reset
      |=> $stable({rx_on, rx_tagged_frames});
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx cfg moved");
  property p_tx_hold;
    tx_frame_active && !host_wr && !tx_soft_reset
      |=> $stable({tx_on, tx_oversize});
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx cfg moved");
  property p_max_len;
    $stable(rx_tagged_frames)
      |-> rx_max_len == (rx_tagged_frames ? 16'h05F2 : 16'h05EE);
  endproperty
  a_max_len: assert property (p_max_len) else $error("rx limit wrong");
  property p_filter;
    host_wr && host_addr == 10'h390 |=> filter_mode_word == $past(host_wdata);
  endproperty
  a_filter: assert property (p_filter) else $error("filter deferred");
  property p_tx_half;
    mac_mode_word[31:30] == 2'b10 && $stable(mac_mode_word) |-> !tx_half_duplex;
  endproperty
  a_tx_half: assert property (p_tx_half) else $error("half at 1000");
endmodule
`default_nettype wire

// [sim/emc_cfg_bank_test.sv]
/* Self-checking bench for the MAC channel configuration bank.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module emc_cfg_bank_test;
  localparam logic [47:0] STN = 48'h112233445566;
  localparam logic [9:0] OFS [12] = '{10'h200, 10'h240, 10'h280, 10'h2C0,
    10'h300, 10'h320, 10'h340, 10'h380, 10'h384, 10'h388, 10'h38C, 10'h390};
  localparam logic [31:0] MSK [12] = '{32'hFFFFFFFF, 32'h7E00FFFF,
    32'h7E000000, 32'h60000000, 32'hFF000000, 32'h00000000, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] host_addr;
  logic host_wr, host_rd, host_rd_valid;
  logic [31:0] host_wdata, host_rdata;
  logic rx_frame_active = 1'b0;
  logic tx_frame_active = 1'b0;
  logic [7:0] client_gap_delay_value = 8'h00;
  logic [31:0] serial_link_status = 32'hFFFFFFFF;
  logic rx_soft_reset, tx_soft_reset, rx_lt_check_off, rx_half_duplex;
  logic rx_tagged_frames, rx_on, rx_pass_checksum, rx_oversize;
  logic tx_gap_adjust, tx_half_duplex, tx_tagged_frames, tx_on;
  logic tx_client_checksum, tx_oversize;
  logic [47:0] rx_pause_address, station_address;
  logic [15:0] rx_max_len;
  logic [7:0] tx_gap_delay;
  logic [31:0] flow_control_word, mac_mode_word, management_word;
  logic [31:0] extra_table_low, extra_table_high, filter_mode_word;
  int errors = 0;
  int n_tests = 0;
  initial forever #25 ref_clk = ~ref_clk;
  // Pause default equals unicast default
  emc_cfg_bank #(.pause_station_address_default(STN),
    .unicast_station_address_default(STN)) dut (.ref_clk, .sys_rst,
    .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
    .host_rd_valid, .rx_frame_active, .tx_frame_active,
    .client_gap_delay_value, .serial_link_status, .rx_soft_reset,
    .tx_soft_reset, .rx_pause_address, .rx_lt_check_off, .rx_half_duplex,
    .rx_tagged_frames, .rx_on, .rx_pass_checksum, .rx_oversize, .rx_max_len,
    .tx_gap_adjust, .tx_half_duplex, .tx_tagged_frames, .tx_on,
    .tx_client_checksum, .tx_oversize, .tx_gap_delay, .flow_control_word,
    .mac_mode_word, .management_word, .station_address, .extra_table_low,
    .extra_table_high, .filter_mode_word);
  emc_host_model host (.ref_clk, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .host_rd_valid);
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    host.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      test_done();
    end
    chk(d, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic t_defaults();
    rdc(10'h200, 32'h33445566);
    rdc(10'h240, 32'h10001122);
    rdc(10'h280, 32'h10000000);
    rdc(10'h320, 32'hC000000F);
    rdc(10'h384, 32'h00001122);
    chk(rx_pause_address, STN);
  endtask
  task automatic t_map();
    int i;
    for (i = 0; i < 12; i++)
      host.wr(OFS[i], 32'h5AA5C33C);
    host.wr(10'h204, 32'hFFFFFFFF);
    chk(station_address, 48'hC33C5AA5C33C);
    chk({flow_control_word[31:24], mac_mode_word[31:24],
      management_word}, 48'h405A5AA5C33C);
    chk({extra_table_high, extra_table_low[15:0]}, 48'h5AA5C33CC33C);
    for (i = 0; i < 12; i++)
      rdc(OFS[i], (i == 5) ? 32'hC000000F : 32'h5AA5C33C & MSK[i]);
    rdc(10'h204, 32'h00000000);
    rdc(10'h3FC, 32'h00000000);
  endtask
  task automatic t_fields();
    int b;
    logic [5:0] oh, rv, tv;
    for (b = 25; b < 31; b++)
    begin
      oh = 6'h01 << (b - 25);
      host.wr(10'h240, 32'h00001122 | (32'h00000001 << b));
      host.wr(10'h280, 32'h00000001 << b);
      idle(3);
      rv = {rx_oversize, rx_pass_checksum, rx_on, rx_tagged_frames,
        rx_half_duplex, rx_lt_check_off};
      tv = {tx_oversize, tx_client_checksum, tx_on, tx_tagged_frames,
        tx_half_duplex, tx_gap_adjust};
      chk(rv, oh);
      chk(tv, oh);
      chk(rx_max_len, (b == 27) ? 16'h05F2 : 16'h05EE);
    end
  endtask
  task automatic t_defer();
    host.wr(10'h200, 32'hDDCCBBAA);
    host.wr(10'h240, 32'h1000FFEE);
    host.wr(10'h280, 32'h10000000);
    idle(3);
    chk(rx_pause_address, 48'hFFEEDDCCBBAA);
    tx_frame_active = 1'b1;
    host.wr(10'h390, 32'hA5A5A5A5);
    chk(filter_mode_word, 32'hA5A5A5A5);
    rx_frame_active = 1'b1;
    host.wr(10'h240, 32'h00001122);
    host.wr(10'h280, 32'h00000000);
    idle(3);
    chk({rx_on, tx_on}, 2'b11);
    rdc(10'h240, 32'h00001122);
    rx_frame_active = 1'b0;
    tx_frame_active = 1'b0;
    idle(3);
    chk({rx_on, tx_on}, 2'b00);
  endtask
  task automatic t_soft_reset();
    rx_frame_active = 1'b1;
    tx_frame_active = 1'b1;
    host.wr(10'h240, 32'h80000000);
    chk(rx_soft_reset, 1'b1);
    idle(3);
    chk(rx_on, 1'b1);
    chk(rx_pause_address, STN);
    rdc(10'h240, 32'h10001122);
    host.wr(10'h280, 32'h80000000);
    chk(tx_soft_reset, 1'b1);
    idle(3);
    chk(tx_on, 1'b1);
    rdc(10'h280, 32'h10000000);
    rx_frame_active = 1'b0;
    tx_frame_active = 1'b0;
  endtask
  task automatic t_speed_gap();
    host.wr(10'h280, 32'h16000000);
    host.wr(10'h300, 32'h80000000);
    idle(3);
    chk(tx_half_duplex, 1'b0);
    host.wr(10'h300, 32'h40000000);
    idle(3);
    chk(tx_half_duplex, 1'b1);
    client_gap_delay_value = 8'h5A;
    tx_frame_active = 1'b1;
    idle(2);
    chk(tx_gap_delay, 8'h5A);
    tx_frame_active = 1'b0;
  endtask
  initial
  begin
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_defaults();
    t_map();
    t_fields();
    t_defer();
    t_soft_reset();
    t_speed_gap();
    test_done();
  end
endmodule
bind emc_cfg_bank emc_cfg_bank_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk,
  .sys_rst, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
  .host_rd_valid, .rx_frame_active, .tx_frame_active, .rx_soft_reset,
  .tx_soft_reset, .rx_on, .rx_tagged_frames, .rx_max_len, .tx_on,
  .tx_oversize, .tx_half_duplex, .mac_mode_word, .filter_mode_word);
`default_nettype wire

// [sim/emc_host_model.sv]
/* Host processor model: single-cycle write and read strobes.
   Assumes the bank answers a read one cycle after the strobe. */
`timescale 1ns/100ps
`default_nettype none
module emc_host_model
(
  input wire logic ref_clk, // Clock
  output logic [9:0] host_addr, // Address
  output logic host_wr, // Write strobe
  output logic host_rd, // Read strobe
  output logic [31:0] host_wdata, // Write data
  input wire logic [31:0] host_rdata, // Read data
  input wire logic host_rd_valid // Read valid
);
  initial
  begin
    host_addr = 10'h000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h00000000;
  end
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    // Inverse on release so stale values cannot pass
    host_wdata = ~d;
    host_addr = ~a;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d,
    output logic ok);
    int i;
    ok = 1'b0;
    d = 32'h00000000;
    @(negedge ref_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge ref_clk);
    host_rd = 1'b0;
    host_addr = ~a;
    for (i = 0; i < 4 && ok == 1'b0; i++)
    begin
      if (host_rd_valid === 1'b1)
      begin
        d = host_rdata;
        ok = 1'b1;
      end
      else
        @(negedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire
